// ### design/weigher_cmd.sv
// diagnostics and calibration command handler of the weigher
//
// Implementation choices: the register offsets and strobed register access.
`default_nettype none
`include "weigher_regs.svh"
// Summary of operation
// (RQ1) type query returns fixed type code
// (RQ2) version query returns lettered release code
// (RQ3) status query returns letter, left, right
// (RQ4) left: stable 1, zero 2, tare 4
// (RQ5) restart acknowledges first, then resets soon
// (RQ6) unlock query returns letter and audit code
// (RQ7) calibration writes need unlock, else error
// (RQ8) three upper limits, over shows zeros
// (RQ9) lower limit, below it under-range
// (RQ10) range mode: interval or range
// (RQ11) only listed step sizes accepted
// (RQ12) higher ranges use next larger steps
// (RQ13) point position zero to six
// (RQ14) zero calibration stores present signal
// (RQ15) span target set or weight read back
// (RQ16) span load below one percent fails
// (RQ17) zero tracking inside half band, slowly
// (RQ18) tracking stays within zero range
// (RQ19) factory restore: defaults, save, bump code
// (RQ20) save stores group, bumps audit code
// (RQ21) parameter queries need no unlock
// (RQ22) stable after band held for time
// (RQ23) out-of-range values rejected, kept unchanged
module weigher_cmd #(
    parameter int          MS_CYC       = `MS_CYC,
    parameter logic [15:0] TYPE_CODE    = 16'hA5C3, // arbitrary value
    parameter logic [15:0] RELEASE_CODE = 16'h0001  // arbitrary value
) (
    input  wire logic                      CLK,
    input  wire logic                      SYS_RST,
    input  wire weigher_pkg::bus_req_t     BUS,
    output logic [31:0]                    RDATA,
    input  wire logic signed [23:0]        SIGNAL,
    input  wire logic                      TARE_ACTIVE,
    input  wire logic                      ZERO_ACTIVE,
    output weigher_pkg::weight_out_t       WEIGHT,
    output logic                           STABLE,
    output logic                           NVM_SAVE,
    output logic                           RESTART
);
// ----------------------------------------
// decoding helpers
// ----------------------------------------
function automatic logic [9:0] step_of(input logic [3:0] i);
    case (i)
        4'h0:    step_of = `STEP_0;
        4'h1:    step_of = `STEP_1;
        4'h2:    step_of = `STEP_2;
        4'h3:    step_of = `STEP_3;
        4'h4:    step_of = `STEP_4;
        4'h5:    step_of = `STEP_5;
        4'h6:    step_of = `STEP_6;
        4'h7:    step_of = `STEP_7;
        default: step_of = `STEP_8;
    endcase
endfunction

function automatic logic [3:0] step_index(input logic signed [31:0] v);
    step_index = `STEP_BAD;
    for (int k = 0; k <= int'(`STEP_LAST); k++) begin
        if (v == 32'(step_of(4'(k))))
            step_index = 4'(k);
    end
endfunction

function automatic logic is_calib(input logic [7:0] a);
    is_calib = (a >= `A_UPPER1) && (a <= `A_LIMIT);
endfunction
// ----------------------------------------
// state
// ----------------------------------------
logic signed [31:0]          arg;
logic                        unlocked;
logic [16:0]                 change_audit_code;
logic signed [23:0]          upper [0:2];
logic signed [23:0]          lower;
logic                        mode;
logic [3:0]                  step_idx;
logic [2:0]                  point;
logic signed [23:0]          cal_zero;
logic signed [23:0]          cur_zero;
logic [23:0]                 cal_weight;
logic [23:0]                 span_raw;
logic [7:0]                  zt;
logic [7:0]                  zr;
logic [15:0]                 band;
logic [15:0]                 stab_time;
logic                        res_err;
logic                        next_err;
logic                        wr_ok;
logic                        zero_ok;
logic                        save_ok;
logic                        fd_ok;
logic signed [24:0]          load;
logic [17:0]                 ms_div;
logic                        tick;
logic signed [23:0]          motion_ref;
logic [15:0]                 still_ms;
logic signed [24:0]          mdiff;
logic signed [24:0]          net;
logic [1:0]                  r_val;
logic [1:0]                  r_eff;
logic [1:0]                  range_hold;
logic [3:0]                  eff_sum;
logic [3:0]                  eff_idx;
logic signed [24:0]          step_sz;
logic signed [24:0]          dstep;
logic signed [24:0]          mag;
logic signed [24:0]          move;
logic signed [24:0]          cand;
logic signed [24:0]          drift;
logic [11:0]                 track_cnt;
logic                        track_due;
logic                        track_ok;
logic [7:0]                  rs_cnt;
weigher_pkg::restart_state_t rs_state;

assign arg  = BUS.wdata;
assign load = 25'(SIGNAL) - 25'(cal_zero);
// ----------------------------------------
// write check
// ----------------------------------------
always_comb begin
    next_err = 1'b1;
    if (is_calib(BUS.addr) && !unlocked) begin
        next_err = 1'b1; // RQ7
    end else begin
        case (BUS.addr)
            `A_AUDIT:  next_err = (arg != 32'(change_audit_code)); // RQ7
            `A_UPPER1, `A_UPPER2, `A_UPPER3:
                next_err = (arg < `UPPER_MIN) || (arg > `UPPER_MAX); // RQ8 RQ23
            `A_LOWER:  next_err = (arg < `LOWER_MIN) || (arg > `LOWER_TOP); // RQ9 RQ23
            `A_MODE:   next_err = (arg < 0) || (arg > `MODE_MAX); // RQ10 RQ23
            `A_STEP:   next_err = (step_index(arg) == `STEP_BAD); // RQ11 RQ23
            `A_POINT:  next_err = (arg < 0) || (arg > `POINT_MAX); // RQ13 RQ23
            // span needs a settled signal and enough load
            `A_SPAN:   next_err = (arg < `UPPER_MIN) || (arg > `UPPER_MAX)
                                  || !STABLE || (load < `SPAN_MIN); // RQ15 RQ16
            `A_FOLLOW, `A_LIMIT:
                next_err = (arg < 0) || (arg > `BAND_MAX); // RQ23
            `A_MBAND, `A_STIME:
                next_err = (arg < 0) || (arg > `TIME_MAX); // RQ23
            default:   next_err = 1'b1;
        endcase
    end
end

assign wr_ok   = BUS.wr && !next_err;
assign zero_ok = BUS.rd && (BUS.addr == `A_ZERO_CAL) && unlocked && STABLE; // RQ14
assign save_ok = BUS.rd && (BUS.addr == `A_SAVE) && unlocked; // RQ20
assign fd_ok   = BUS.rd && (BUS.addr == `A_FACTORY) && unlocked; // RQ19

always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
        res_err <= 1'b0;
    else if (BUS.wr)
        res_err <= next_err;
end
// ----------------------------------------
// access code and unlock
// ----------------------------------------
always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
        change_audit_code <= `TAC_RESET;
    else if (save_ok || fd_ok)
        change_audit_code <= (change_audit_code == `TAC_MAX) ? `TAC_RESET : change_audit_code + 17'h00001; // RQ19 RQ20
end

// a save relocks so the next calibration change needs a fresh code
always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
        unlocked <= 1'b0;
    else if (save_ok || fd_ok)
        unlocked <= 1'b0;
    else if (BUS.wr && BUS.addr == `A_AUDIT)
        unlocked <= !next_err; // RQ7
end
// ----------------------------------------
// calibration group
// ----------------------------------------
for (genvar g = 0; g < 3; g++) begin : g_upper
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST)
            upper[g] <= (g == 0) ? `UPPER1_DEF : `UPPER_REST;
        else if (fd_ok)
            upper[g] <= (g == 0) ? `UPPER1_DEF : `UPPER_REST; // RQ19
        else if (wr_ok && BUS.addr == `A_UPPER1 + 8'(g))
            upper[g] <= arg[23:0]; // RQ8
    end
end

// reset branch kept apart so the async reset sees constants only
always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        lower     <= `LOWER_DEF;
        mode      <= `MODE_DEF;
        step_idx  <= `STEP_DEF;
        point     <= `POINT_DEF;
        zt        <= `FOLLOW_DEF;
        zr        <= `LIMIT_DEF;
        band      <= `MBAND_DEF;
        stab_time <= `STIME_DEF;
    end else if (fd_ok) begin
        lower     <= `LOWER_DEF; // RQ19
        mode      <= `MODE_DEF;
        step_idx  <= `STEP_DEF;
        point     <= `POINT_DEF;
        zt        <= `FOLLOW_DEF;
        zr        <= `LIMIT_DEF;
        band      <= `MBAND_DEF;
        stab_time <= `STIME_DEF;
    end else if (wr_ok) begin
        case (BUS.addr)
            `A_LOWER:  lower     <= arg[23:0]; // RQ9
            `A_MODE:   mode      <= arg[0]; // RQ10
            `A_STEP:   step_idx  <= step_index(arg); // RQ11
            `A_POINT:  point     <= arg[2:0]; // RQ13
            `A_FOLLOW: zt        <= arg[7:0]; // RQ17
            `A_LIMIT:  zr        <= arg[7:0]; // RQ18
            `A_MBAND:  band      <= arg[15:0]; // RQ22
            `A_STIME:  stab_time <= arg[15:0]; // RQ22
            default:   lower     <= lower;
        endcase
    end
end

always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        cal_weight <= `WORD_DEF;
        span_raw   <= `WORD_DEF;
    end else if (fd_ok) begin
        cal_weight <= `WORD_DEF;
        span_raw   <= `WORD_DEF;
    end else if (wr_ok && BUS.addr == `A_SPAN) begin
        cal_weight <= arg[23:0]; // RQ15
        span_raw   <= load[23:0];
    end
end

always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
        cal_zero <= `WORD_DEF;
    else if (fd_ok)
        cal_zero <= `WORD_DEF;
    else if (zero_ok)
        cal_zero <= SIGNAL; // RQ14
end
// ----------------------------------------
// millisecond tick and stability
// ----------------------------------------
assign tick = (ms_div == 18'(MS_CYC - 1));

always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
        ms_div <= 18'h00000;
    else
        ms_div <= tick ? 18'h00000 : ms_div + 18'h00001;
end

assign mdiff = 25'(SIGNAL) - 25'(motion_ref);

// any excursion beyond the band restarts the quiet period
always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        motion_ref <= `WORD_DEF;
        still_ms   <= 16'h0000;
    end else if (mdiff > $signed(25'(band)) || -mdiff > $signed(25'(band))) begin
        motion_ref <= SIGNAL; // RQ22
        still_ms   <= 16'h0000;
    end else if (tick && still_ms != 16'hFFFF) begin
        still_ms <= still_ms + 16'h0001;
    end
end

always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
        STABLE <= 1'b0;
    else
        STABLE <= (still_ms >= stab_time) && (mdiff <= $signed(25'(band)))
                  && (-mdiff <= $signed(25'(band))); // RQ22
end
// ----------------------------------------
// ranges, steps and output
// ----------------------------------------
assign net = 25'(SIGNAL) - 25'(cur_zero);

always_comb begin
    if (upper[1] == 0 || net <= 25'(upper[0]))
        r_val = 2'h0;
    else if (upper[2] == 0 || net <= 25'(upper[1]))
        r_val = 2'h1;
    else
        r_val = 2'h2;
    // multi-range keeps the highest range reached until back at zero
    r_eff   = (mode && range_hold > r_val) ? range_hold : r_val; // RQ10
    eff_sum = step_idx + {2'h0, r_eff}; // RQ12
    eff_idx = (eff_sum > `STEP_LAST) ? `STEP_LAST : eff_sum; // RQ12
    step_sz = $signed({15'h0000, step_of(eff_idx)});
end

always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
        range_hold <= 2'h0;
    else
        range_hold <= (net <= 0) ? 2'h0 : r_eff;
end

always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        WEIGHT <= '0;
    end else begin
        WEIGHT.over  <= net > 25'(upper[r_eff]); // RQ8
        WEIGHT.under <= net < 25'(lower); // RQ9
        WEIGHT.point <= point; // RQ13
        if (net > 25'(upper[r_eff]) || net < 25'(lower))
            WEIGHT.value <= `WORD_DEF;
        else
            WEIGHT.value <= 24'((net / step_sz) * step_sz); // RQ11
    end
end
// ----------------------------------------
// zero tracking
// ----------------------------------------
// one division per 2.5 s gives the slow tracking rate
assign track_due = tick && (track_cnt == `TRACK_MS - 12'h001);
assign dstep     = $signed({15'h0000, step_of(step_idx)});
assign mag       = (net < 0) ? -net : net;
assign move      = (mag < dstep) ? mag : dstep;
assign cand      = (net < 0) ? 25'(cur_zero) - move : 25'(cur_zero) + move;
assign drift     = cand - 25'(cal_zero);
assign track_ok  = (zt != 8'h00) && STABLE
                   && ((mag + mag) < $signed(25'(zt)) * dstep); // RQ17

always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
        track_cnt <= 12'h000;
    else if (track_due)
        track_cnt <= 12'h000;
    else if (tick)
        track_cnt <= track_cnt + 12'h001;
end

always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
        cur_zero <= `WORD_DEF;
    else if (fd_ok)
        cur_zero <= `WORD_DEF;
    else if (zero_ok)
        cur_zero <= SIGNAL; // RQ14
    else if (track_due && track_ok && drift <= $signed(25'(zr)) * dstep
             && -drift <= $signed(25'(zr)) * dstep)
        cur_zero <= cand[23:0]; // RQ17 RQ18
end
// ----------------------------------------
// restart and save strobes
// ----------------------------------------
always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        rs_state <= weigher_pkg::RS_IDLE;
        rs_cnt   <= 8'h00;
        RESTART  <= 1'b0;
    end else begin
        RESTART <= 1'b0;
        case (rs_state)
            weigher_pkg::RS_IDLE: begin
                rs_cnt <= 8'h00;
                if (BUS.rd && BUS.addr == `A_RESTART)
                    rs_state <= weigher_pkg::RS_WAIT; // RQ5
            end
            weigher_pkg::RS_WAIT: begin
                rs_cnt <= rs_cnt + 8'h01;
                if (rs_cnt == `RESTART_CYC)
                    rs_state <= weigher_pkg::RS_FIRE;
            end
            weigher_pkg::RS_FIRE: begin
                RESTART  <= 1'b1; // RQ5
                rs_state <= weigher_pkg::RS_IDLE;
            end
            default: rs_state <= weigher_pkg::RS_IDLE;
        endcase
    end
end

always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
        NVM_SAVE <= 1'b0;
    else
        NVM_SAVE <= save_ok || fd_ok; // RQ19 RQ20
end
// ----------------------------------------
// read replies
// ----------------------------------------
always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        RDATA <= `RSP_OK;
    end else if (BUS.rd) begin
        case (BUS.addr)
            `A_TYPE:     RDATA <= {`CH_TYPE, 8'h00, TYPE_CODE}; // RQ1
            `A_RELEASE:  RDATA <= {`CH_REL, 8'h00, RELEASE_CODE}; // RQ2
            `A_STATUS:   RDATA <= {`CH_STAT, 8'h00, 5'h00, TARE_ACTIVE,
                                   ZERO_ACTIVE, STABLE, 8'h00}; // RQ3 RQ4
            `A_RESTART:  RDATA <= `RSP_OK; // RQ5
            `A_AUDIT:    RDATA <= {`CH_AUDIT, 7'h00, change_audit_code}; // RQ6
            `A_UPPER1:   RDATA <= 32'(upper[0]); // RQ21
            `A_UPPER2:   RDATA <= 32'(upper[1]);
            `A_UPPER3:   RDATA <= 32'(upper[2]);
            `A_LOWER:    RDATA <= 32'(lower);
            `A_MODE:     RDATA <= {31'h00000000, mode};
            `A_STEP:     RDATA <= {22'h000000, step_of(step_idx)};
            `A_POINT:    RDATA <= {29'h00000000, point};
            `A_ZERO_CAL: RDATA <= zero_ok ? `RSP_OK : `RSP_ERR; // RQ14
            `A_SPAN:     RDATA <= {8'h00, cal_weight}; // RQ15
            `A_FOLLOW:   RDATA <= {24'h000000, zt};
            `A_LIMIT:    RDATA <= {24'h000000, zr};
            `A_FACTORY:  RDATA <= fd_ok ? `RSP_OK : `RSP_ERR; // RQ19
            `A_SAVE:     RDATA <= save_ok ? `RSP_OK : `RSP_ERR; // RQ20
            `A_MBAND:    RDATA <= {16'h0000, band};
            `A_STIME:    RDATA <= {16'h0000, stab_time};
            `A_RESULT:   RDATA <= res_err ? `RSP_ERR : `RSP_OK;
            default:     RDATA <= `RSP_ERR;
        endcase
    end else begin
        RDATA <= `RSP_OK;
    end
end
// ----------------------------------------
// checks
// ----------------------------------------
localparam int RS_BOUND = 20;

chk_locked_write: assert property ( // RQ7
    @(posedge CLK) disable iff (SYS_RST)
    BUS.wr && is_calib(BUS.addr) && !unlocked |=> res_err && !unlocked)
    else $error("calibration write taken while locked");
chk_tac_step: assert property ( // RQ20
    @(posedge CLK) disable iff (SYS_RST)
    save_ok && change_audit_code != `TAC_MAX |=> change_audit_code == $past(change_audit_code) + 17'h00001 && NVM_SAVE)
    else $error("audit code not bumped on save");
chk_restart_delay: assert property ( // RQ5
    @(posedge CLK) disable iff (SYS_RST)
    BUS.rd && BUS.addr == `A_RESTART && rs_state == weigher_pkg::RS_IDLE
    |=> RDATA == `RSP_OK ##[1:RS_BOUND] RESTART)
    else $error("restart not acknowledged then fired");
chk_status_bits: assert property ( // RQ4
    @(posedge CLK) disable iff (SYS_RST)
    BUS.rd && BUS.addr == `A_STATUS
    |=> RDATA[15:8] == {5'h00, $past(TARE_ACTIVE), $past(ZERO_ACTIVE), $past(STABLE)}
        && RDATA[7:0] == 8'h00)
    else $error("status bits wrong");
chk_type_reply: assert property ( // RQ1
    @(posedge CLK) disable iff (SYS_RST)
    BUS.rd && BUS.addr == `A_TYPE |=> RDATA == {`CH_TYPE, 8'h00, TYPE_CODE})
    else $error("type reply wrong");
chk_step_keep: assert property ( // RQ11
    @(posedge CLK) disable iff (SYS_RST)
    BUS.wr && BUS.addr == `A_STEP && step_index(arg) == `STEP_BAD
    |=> $stable(step_idx) && res_err)
    else $error("bad step size accepted");
chk_point_range: assert property ( // RQ13
    @(posedge CLK) disable iff (SYS_RST)
    WEIGHT.point <= 3'h6)
    else $error("point position out of range");
chk_audit_reply: assert property ( // RQ6
    @(posedge CLK) disable iff (SYS_RST)
    BUS.rd && BUS.addr == `A_AUDIT |=> RDATA == {`CH_AUDIT, 7'h00, $past(change_audit_code)})
    else $error("unlock reply wrong");
chk_query_free: assert property ( // RQ21
    @(posedge CLK) disable iff (SYS_RST)
    BUS.rd && BUS.addr == `A_LOWER && !unlocked |=> RDATA == 32'($past(lower)))
    else $error("query needs unlock");

endmodule // weigher_cmd
`default_nettype wire

// ### shared/weigher_regs.svh
// command addresses, field limits, reset values and timing constants
`ifndef WEIGHER_REGS_SVH
`define WEIGHER_REGS_SVH
// ----------------------------------------
// command addresses
// ----------------------------------------
`define A_TYPE      8'h00
`define A_RELEASE   8'h01
`define A_STATUS    8'h02
`define A_RESTART   8'h03
`define A_AUDIT     8'h04
`define A_UPPER1    8'h05
`define A_UPPER2    8'h06
`define A_UPPER3    8'h07
`define A_LOWER     8'h08
`define A_MODE      8'h09
`define A_STEP      8'h0A
`define A_POINT     8'h0B
`define A_ZERO_CAL  8'h0C
`define A_SPAN      8'h0D
`define A_FOLLOW    8'h0E
`define A_LIMIT     8'h0F
`define A_FACTORY   8'h10
`define A_SAVE      8'h11
`define A_MBAND     8'h12
`define A_STIME     8'h13
`define A_RESULT    8'h14
// ----------------------------------------
// reply words
// ----------------------------------------
`define RSP_OK      32'h00000000
`define RSP_ERR     32'h80000000
`define CH_TYPE     8'h44
`define CH_REL      8'h56
`define CH_STAT     8'h53
`define CH_AUDIT    8'h45
// ----------------------------------------
// accepted argument limits
// ----------------------------------------
`define UPPER_MIN   32'sh00000001
`define UPPER_MAX   32'sh000F423F
`define LOWER_MIN   (-32'sh000F423F)
`define LOWER_TOP   32'sh00000000
`define MODE_MAX    32'sh00000001
`define POINT_MAX   32'sh00000006
`define BAND_MAX    32'sh000000FF
`define TIME_MAX    32'sh0000FFFF
// ----------------------------------------
// reset and factory values
// ----------------------------------------
`define UPPER1_DEF  24'sh0F423F
`define UPPER_REST  24'sh000000
`define LOWER_DEF   (-24'sh000009)
`define MODE_DEF    1'h0
`define STEP_DEF    4'h0
`define POINT_DEF   3'h3
`define FOLLOW_DEF  8'h00
`define LIMIT_DEF   8'h02
`define MBAND_DEF   16'h0001
`define STIME_DEF   16'h03E8
`define WORD_DEF    24'h000000
`define TAC_RESET   17'h00000
`define TAC_MAX     17'h1869F
// ----------------------------------------
// permitted step sizes, smallest first
// ----------------------------------------
`define STEP_0      10'h001
`define STEP_1      10'h002
`define STEP_2      10'h005
`define STEP_3      10'h00A
`define STEP_4      10'h014
`define STEP_5      10'h032
`define STEP_6      10'h064
`define STEP_7      10'h0C8
`define STEP_8      10'h1F4
`define STEP_LAST   4'h8
`define STEP_BAD    4'hF
// ----------------------------------------
// span load and timing
// ----------------------------------------
`define FULL_SCALE  25'sh007D000
`define SPAN_MIN    (`FULL_SCALE / 25'sh0000064)
`define CLK_HZ      32'h0BEBC200
`define MS_PER_S    32'h000003E8
`define MS_CYC      (`CLK_HZ / `MS_PER_S)
`define TRACK_MS    12'h9C4
`define RESTART_CYC 8'h10
`endif

// ### shared/weigher_pkg.sv
// types shared by the weigher command handler
`default_nettype none
package weigher_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;
    typedef struct packed {
        logic signed [23:0] value;
        logic               over;
        logic               under;
        logic [2:0]         point;
    } weight_out_t;
    typedef enum logic [1:0] {RS_IDLE, RS_WAIT, RS_FIRE} restart_state_t;
endpackage
`default_nettype wire

// ### sim/weigher_host.sv
// host-side command master that drives the weigher command bus
`default_nettype none
`include "weigher_regs.svh"
module weigher_host (
    input  wire logic             CLK,
    input  wire logic [31:0]      RDATA,
    output weigher_pkg::bus_req_t BUS
);
    timeunit 1ns;
    timeprecision 1ps;
    initial BUS = '0;
    // strobes last one cycle; address and data simply stay after release
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        BUS <= '{a, d, 1'b1, 1'b0};
        @(posedge CLK);
        BUS.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge CLK);
        BUS <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge CLK);
        BUS.rd <= 1'b0;
        #1 q = RDATA;
    endtask
    // a wrong code is sent only when the bench asks for one
    task automatic unlock(input int code);
        wr(`A_AUDIT, code);
    endtask
endmodule // weigher_host
`default_nettype wire

// ### sim/weigher_cmd_test.sv
// self-checking bench of the weigher command handler
`default_nettype none
`include "weigher_regs.svh"
module weigher_cmd_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] TCODE = 16'h2B7E; // arbitrary value
    localparam logic [15:0] RCODE = 16'h0C31; // arbitrary value
    logic                     CLK = 1'b0;
    logic                     SYS_RST = 1'b1;
    logic [31:0]              RDATA;
    weigher_pkg::bus_req_t    BUS;
    logic signed [23:0]       SIGNAL = 24'sh001000;
    logic                     TARE_ACTIVE = 1'b0;
    logic                     ZERO_ACTIVE = 1'b0;
    weigher_pkg::weight_out_t WEIGHT;
    logic                     STABLE;
    logic                     NVM_SAVE;
    logic                     RESTART;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    int code = 0;
    int z;
    int n;
    int steps[$] = '{1, 2, 5, 10, 20, 50, 100, 200, 500};
    int defs[int] = '{5:999999, 6:0, 7:0, 8:-9, 9:0, 10:1, 11:3, 13:0, 14:0, 15:2,
                      18:1, 19:1000};
    int par[int];
    weigher_cmd #(.MS_CYC(10), .TYPE_CODE(TCODE), .RELEASE_CODE(RCODE)) i_weigher_cmd (
        .CLK(CLK), .SYS_RST(SYS_RST), .BUS(BUS), .RDATA(RDATA), .SIGNAL(SIGNAL),
        .TARE_ACTIVE(TARE_ACTIVE), .ZERO_ACTIVE(ZERO_ACTIVE), .WEIGHT(WEIGHT),
        .STABLE(STABLE), .NVM_SAVE(NVM_SAVE), .RESTART(RESTART));
    weigher_host i_weigher_host (.CLK(CLK), .RDATA(RDATA), .BUS(BUS));
    always #2.5 CLK = ~CLK;
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("compares %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // sample one step after the edge so registered outputs have landed
    task automatic tick(input int k);
        repeat (k) @(posedge CLK);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] q;
        i_weigher_host.rd(a, q);
        check(q, want);
    endtask
    task automatic put(input logic [7:0] a, input int v, input bit ok);
        i_weigher_host.wr(a, v);
        rd_chk(`A_RESULT, ok ? `RSP_OK : `RSP_ERR);
        if (ok) par[a] = v;
        rd_chk(a, par[a]);
    endtask
    task automatic all_pars();
        foreach (par[k]) rd_chk(8'(k), par[k]);
        rd_chk(`A_AUDIT, {`CH_AUDIT, 7'h00, 17'(code)});
    endtask
    // a large step drops stability; 20 ms of 10 cycles must pass again
    task automatic settle(input int s);
        @(posedge CLK);
        SIGNAL <= s[23:0];
        tick(3);
        check(STABLE, 0);
        tick(170);
        check(STABLE, 0);
        tick(60);
        check(STABLE, 1);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'h49203a6d));
        par = defs;
        tick(12);
        SYS_RST <= 1'b0;
        all_pars();
        rd_chk(`A_TYPE, {`CH_TYPE, 8'h00, TCODE});
        rd_chk(`A_RELEASE, {`CH_REL, 8'h00, RCODE});
        put(`A_POINT, 5, 0);
        i_weigher_host.unlock(code + 1);
        put(`A_POINT, 5, 0);
        i_weigher_host.unlock(code);
        put(`A_POINT, 6, 1);
        check(WEIGHT.point, 6);
        put(`A_POINT, 7, 0);
        put(`A_MODE, 2, 0);
        put(`A_MODE, 1, 1);
        put(`A_UPPER1, 0, 0);
        put(`A_UPPER1, 1000000, 0);
        put(`A_UPPER2, 999999, 1);
        put(`A_LOWER, 1, 0);
        put(`A_LOWER, -1000000, 0);
        put(`A_LOWER, -999999, 1);
        put(`A_STEP, 3, 0);
        foreach (steps[i]) put(`A_STEP, steps[i], 1);
        put(`A_FOLLOW, 256, 0);
        rd_chk(`A_SAVE, `RSP_OK);
        check(NVM_SAVE, 1);
        code++;
        put(`A_POINT, 2, 0);
        i_weigher_host.unlock(code);
        rd_chk(`A_FACTORY, `RSP_OK);
        check(NVM_SAVE, 1);
        code++;
        par = defs;
        all_pars();
        put(`A_STIME, 20, 1);
        z = 100000 + $urandom_range(0, 99999);
        settle(z);
        for (int i = 0; i < 4; i++) begin
            @(posedge CLK);
            TARE_ACTIVE <= i[0];
            ZERO_ACTIVE <= i[1];
            rd_chk(`A_STATUS, {16'h5300, 5'h00, i[0], i[1], 1'b1, 8'h00});
        end
        i_weigher_host.unlock(code);
        rd_chk(`A_ZERO_CAL, `RSP_OK);
        tick(4);
        check(WEIGHT.value, 0);
        SIGNAL <= 24'(z - 10);
        tick(4);
        check({WEIGHT.under, WEIGHT.value}, {1'b1, 24'h0});
        SIGNAL <= 24'(z - 9);
        tick(4);
        check({WEIGHT.under, WEIGHT.value}, {1'b0, 24'hFFFFF7});
        SIGNAL <= 24'(z + 1000000);
        tick(4);
        check({WEIGHT.over, WEIGHT.value}, {1'b1, 24'h0});
        settle(z);
        put(`A_SPAN, 25000, 0);
        settle(z + 6000);
        put(`A_SPAN, 25000, 1);
        put(`A_UPPER1, 5000, 1);
        check(WEIGHT.over, 1);
        put(`A_UPPER2, 999999, 1);
        SIGNAL <= 24'(z + 6001);
        tick(4);
        check(STABLE, 1);
        check(WEIGHT.value, 6000);
        rd_chk(`A_RESTART, `RSP_OK);
        n = 0;
        while (RESTART !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        check(RESTART, 1);
        stop_test();
    end
endmodule // weigher_cmd_test
`default_nettype wire
